//--- shared/pmd_bank_pkg.sv
// Package with register map, field masks and timing constants of the peripheral disable bank
package pmd_bank_pkg;

  // Register byte addresses on APB, one aligned word per register
  localparam logic [11:0] ADDR_TIMER_NCO   = 12'h004;
  localparam logic [11:0] ADDR_ANALOG      = 12'h008;
  localparam logic [11:0] ADDR_PWM_CAPTURE = 12'h00C;
  localparam logic [11:0] ADDR_WAVEFORM    = 12'h010;
  localparam logic [11:0] ADDR_SERIAL      = 12'h014;
  localparam logic [11:0] ADDR_LOGIC_CELL  = 12'h018;
  localparam logic [11:0] ADDR_DMA_ENGINE  = 12'h01C;
  localparam logic [11:0] ADDR_STATUS      = 12'h020;

  localparam int NUM_REGS = 7;
  localparam int NUM_PERIPH = 56;

  // Writable bit masks per register; zeros are unimplemented positions
  localparam logic [7:0] MASK_TIMER_NCO   = 8'hFF;
  localparam logic [7:0] MASK_ANALOG      = 8'h67;
  localparam logic [7:0] MASK_PWM_CAPTURE = 8'hFF;
  localparam logic [7:0] MASK_WAVEFORM    = 8'hE0;
  localparam logic [7:0] MASK_SERIAL      = 8'h37;
  localparam logic [7:0] MASK_LOGIC_CELL  = 8'h3F;
  localparam logic [7:0] MASK_DMA_ENGINE  = 8'h03;

  // Reset value of every disable register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Bit position of the zero-cross disable inside the analog register
  localparam int ZERO_CROSS_BIT = 0;

  // Hold-off after a peripheral restarts, one instruction cycle
  localparam int CLK_PERIOD_NS    = 40;
  localparam int RESTART_HOLD_NS  = 40;
  localparam int RESTART_HOLD_CYC = (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus answer data for unmapped addresses
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

//--- hdl/periph_gate.sv
`timescale 1ns/1ps
// One peripheral stop/restart gate: clock enable, reset hold and restart hold-off
module periph_gate (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic off_bit,
  output logic      clk_en,
  output logic      reset_hold,
  output logic      restart_busy
);

  typedef struct packed {
    logic clk_en;
    logic reset_hold;
    logic busy;
  } gate_state_t;

  gate_state_t s_q;
  gate_state_t s_d;

  // Off bit stops the clock and holds reset; falling edge marks the restart window
  always_comb begin
    s_d            = s_q;
    s_d.clk_en     = ~off_bit;
    s_d.reset_hold = off_bit;
    s_d.busy       = s_q.reset_hold & ~off_bit;
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{clk_en: 1'b1, reset_hold: 1'b0, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_en       = s_q.clk_en;
  assign reset_hold   = s_q.reset_hold;
  assign restart_busy = s_q.busy;

  a_gate_follows: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (reset_hold == $past(off_bit)) && (clk_en == !$past(off_bit)))
    else $error("gate does not follow off bit");

endmodule

//--- hdl/pmd_bank.sv
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Peripheral module disable bank: seven disable registers on APB driving per-peripheral gates
module pmd_bank (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        zero_cross_fuse_word,
  output logic [55:0]      periph_clk_en,
  output logic [55:0]      periph_reset_hold,
  output logic [55:0]      periph_restart_busy,
  output logic [55:0]      periph_access_block
);

  typedef struct packed {
    logic [7:0]  timer_nco_disable;
    logic [7:0]  analog_disable;
    logic [7:0]  pwm_capture_disable;
    logic [7:0]  waveform_gen_disable;
    logic [7:0]  serial_port_disable;
    logic [7:0]  logic_cell_disable;
    logic [7:0]  dma_engine_disable;
    logic [31:0] rdata;
    logic        slverr;
    logic        fuse_allows;
    logic        ack;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;

  logic        setup_wr;
  logic        access;
  logic        addr_hit;
  logic [7:0]  wbyte;
  logic [55:0] off_vec;
  logic [55:0] busy_vec;
  logic        busy_any;
  logic        ack_q;
  logic        osc_gen_off, timer_six_off, timer_five_off, timer_four_off;
  logic        timer_three_off, timer_two_off, timer_one_off, timer_zero_off;
  logic        dac_off, adc_off, comparator_two_off, comparator_one_off, zero_cross_off;
  logic        pwm_eight_off, pwm_seven_off, pwm_six_off, pwm_five_off;
  logic        capcomp_four_off, capcomp_three_off, capcomp_two_off, capcomp_one_off;
  logic        waveform_three_off, waveform_two_off, waveform_one_off;
  logic        uart_two_off, uart_one_off, spi_port_off, i2c_two_off, i2c_one_off;
  logic        signal_timer_off, logic_cell_four_off, logic_cell_three_off;
  logic        logic_cell_two_off, logic_cell_one_off, modulator_off;
  logic        dma_two_off, dma_one_off;

  // Single-wait APB slave: answer in the second access cycle
  assign access   = psel & penable;
  assign setup_wr = access & pwrite & pstrb[0];
  assign wbyte    = pwdata[7:0];

  // Address decode for mapped registers and the restart status word
  always_comb begin
    addr_hit = 1'b1;
    unique case (paddr)
      pmd_bank_pkg::ADDR_TIMER_NCO,
      pmd_bank_pkg::ADDR_ANALOG,
      pmd_bank_pkg::ADDR_PWM_CAPTURE,
      pmd_bank_pkg::ADDR_WAVEFORM,
      pmd_bank_pkg::ADDR_SERIAL,
      pmd_bank_pkg::ADDR_LOGIC_CELL,
      pmd_bank_pkg::ADDR_DMA_ENGINE,
      pmd_bank_pkg::ADDR_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Next-state logic: register writes masked to implemented bits, read mux, error flag
  always_comb begin
    s_d             = s_q;
    s_d.fuse_allows = zero_cross_fuse_word;
    s_d.slverr      = 1'b0;
    s_d.rdata       = pmd_bank_pkg::READ_ZERO;
    s_d.ack         = access & ~s_q.ack;
    if (setup_wr) begin
      unique case (paddr)
        pmd_bank_pkg::ADDR_TIMER_NCO:   s_d.timer_nco_disable    = wbyte & pmd_bank_pkg::MASK_TIMER_NCO;
        pmd_bank_pkg::ADDR_ANALOG:      s_d.analog_disable       = wbyte & pmd_bank_pkg::MASK_ANALOG;
        pmd_bank_pkg::ADDR_PWM_CAPTURE: s_d.pwm_capture_disable  = wbyte & pmd_bank_pkg::MASK_PWM_CAPTURE;
        pmd_bank_pkg::ADDR_WAVEFORM:    s_d.waveform_gen_disable = wbyte & pmd_bank_pkg::MASK_WAVEFORM;
        pmd_bank_pkg::ADDR_SERIAL:      s_d.serial_port_disable  = wbyte & pmd_bank_pkg::MASK_SERIAL;
        pmd_bank_pkg::ADDR_LOGIC_CELL:  s_d.logic_cell_disable   = wbyte & pmd_bank_pkg::MASK_LOGIC_CELL;
        pmd_bank_pkg::ADDR_DMA_ENGINE:  s_d.dma_engine_disable   = wbyte & pmd_bank_pkg::MASK_DMA_ENGINE;
        default: s_d.slverr = 1'b0;
      endcase
    end
    if (access & ~pwrite) begin
      unique case (paddr)
        pmd_bank_pkg::ADDR_TIMER_NCO:   s_d.rdata = {24'h00_0000, s_q.timer_nco_disable};
        pmd_bank_pkg::ADDR_ANALOG:      s_d.rdata = {24'h00_0000, s_q.analog_disable};
        pmd_bank_pkg::ADDR_PWM_CAPTURE: s_d.rdata = {24'h00_0000, s_q.pwm_capture_disable};
        pmd_bank_pkg::ADDR_WAVEFORM:    s_d.rdata = {24'h00_0000, s_q.waveform_gen_disable};
        pmd_bank_pkg::ADDR_SERIAL:      s_d.rdata = {24'h00_0000, s_q.serial_port_disable};
        pmd_bank_pkg::ADDR_LOGIC_CELL:  s_d.rdata = {24'h00_0000, s_q.logic_cell_disable};
        pmd_bank_pkg::ADDR_DMA_ENGINE:  s_d.rdata = {24'h00_0000, s_q.dma_engine_disable};
        pmd_bank_pkg::ADDR_STATUS:      s_d.rdata = {31'h0000_0000, busy_any};
        default: s_d.rdata = pmd_bank_pkg::READ_ZERO;
      endcase
    end
    if (access & ~addr_hit) begin
      s_d.slverr = 1'b1;
    end
  end

  // State register, all disable bits clear on reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{timer_nco_disable:    pmd_bank_pkg::REG_RESET,
               analog_disable:       pmd_bank_pkg::REG_RESET,
               pwm_capture_disable:  pmd_bank_pkg::REG_RESET,
               waveform_gen_disable: pmd_bank_pkg::REG_RESET,
               serial_port_disable:  pmd_bank_pkg::REG_RESET,
               logic_cell_disable:   pmd_bank_pkg::REG_RESET,
               dma_engine_disable:   pmd_bank_pkg::REG_RESET,
               rdata:                pmd_bank_pkg::READ_ZERO,
               slverr:               1'b0,
               fuse_allows:          1'b0,
               ack:                  1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Acknowledge flop lives in the state struct; high in the second access cycle only
  assign ack_q    = s_q.ack;
  assign busy_any = |busy_vec;

  // Answer on the second access cycle so read data comes from flip-flops
  assign pready  = ack_q;
  assign prdata  = ack_q ? s_q.rdata : pmd_bank_pkg::READ_ZERO;
  assign pslverr = ack_q & s_q.slverr;

  // Timer register: oscillator generator on top, timers six to zero below
  assign osc_gen_off     = s_q.timer_nco_disable[7];
  assign timer_six_off   = s_q.timer_nco_disable[6];
  assign timer_five_off  = s_q.timer_nco_disable[5];
  assign timer_four_off  = s_q.timer_nco_disable[4];
  assign timer_three_off = s_q.timer_nco_disable[3];
  assign timer_two_off   = s_q.timer_nco_disable[2];
  assign timer_one_off   = s_q.timer_nco_disable[1];
  assign timer_zero_off  = s_q.timer_nco_disable[0];

  // Analog register; zero-cross disable honoured only when the fuse leaves it to software
  assign dac_off            = s_q.analog_disable[6];
  assign adc_off            = s_q.analog_disable[5];
  assign comparator_two_off = s_q.analog_disable[2];
  assign comparator_one_off = s_q.analog_disable[1];
  assign zero_cross_off     = s_q.analog_disable[pmd_bank_pkg::ZERO_CROSS_BIT] & s_q.fuse_allows;

  // PWM register: PWM units eight to five, then capture units four to one
  assign pwm_eight_off     = s_q.pwm_capture_disable[7];
  assign pwm_seven_off     = s_q.pwm_capture_disable[6];
  assign pwm_six_off       = s_q.pwm_capture_disable[5];
  assign pwm_five_off      = s_q.pwm_capture_disable[4];
  assign capcomp_four_off  = s_q.pwm_capture_disable[3];
  assign capcomp_three_off = s_q.pwm_capture_disable[2];
  assign capcomp_two_off   = s_q.pwm_capture_disable[1];
  assign capcomp_one_off   = s_q.pwm_capture_disable[0];

  // Waveform register: generators three to one in the top bits
  assign waveform_three_off = s_q.waveform_gen_disable[7];
  assign waveform_two_off   = s_q.waveform_gen_disable[6];
  assign waveform_one_off   = s_q.waveform_gen_disable[5];

  // Serial register: two UARTs, the SPI port and two I2C ports
  assign uart_two_off = s_q.serial_port_disable[5];
  assign uart_one_off = s_q.serial_port_disable[4];
  assign spi_port_off = s_q.serial_port_disable[2];
  assign i2c_two_off  = s_q.serial_port_disable[1];
  assign i2c_one_off  = s_q.serial_port_disable[0];

  // Logic-cell register: signal timer, four cells and the modulator
  assign signal_timer_off     = s_q.logic_cell_disable[5];
  assign logic_cell_four_off  = s_q.logic_cell_disable[4];
  assign logic_cell_three_off = s_q.logic_cell_disable[3];
  assign logic_cell_two_off   = s_q.logic_cell_disable[2];
  assign logic_cell_one_off   = s_q.logic_cell_disable[1];
  assign modulator_off        = s_q.logic_cell_disable[0];

  // DMA register: two engines in the low bits
  assign dma_two_off = s_q.dma_engine_disable[1];
  assign dma_one_off = s_q.dma_engine_disable[0];

  // Flat per-peripheral disable vector; empty positions are tied off so no stray bit can stop a slot
  assign off_vec = {osc_gen_off, timer_six_off, timer_five_off, timer_four_off,
                    timer_three_off, timer_two_off, timer_one_off, timer_zero_off,
                    1'h0, dac_off, adc_off, 2'h0, comparator_two_off, comparator_one_off, zero_cross_off,
                    pwm_eight_off, pwm_seven_off, pwm_six_off, pwm_five_off,
                    capcomp_four_off, capcomp_three_off, capcomp_two_off, capcomp_one_off,
                    waveform_three_off, waveform_two_off, waveform_one_off, 5'h00,
                    2'h0, uart_two_off, uart_one_off, 1'h0, spi_port_off, i2c_two_off, i2c_one_off,
                    2'h0, signal_timer_off, logic_cell_four_off, logic_cell_three_off,
                    logic_cell_two_off, logic_cell_one_off, modulator_off,
                    6'h00, dma_two_off, dma_one_off};

  // One gate per peripheral slot
  genvar gi;
  generate
    for (gi = 0; gi < pmd_bank_pkg::NUM_PERIPH; gi++) begin : g_gate
      periph_gate u_gate (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .off_bit      (off_vec[gi]),
        .clk_en       (periph_clk_en[gi]),
        .reset_hold   (periph_reset_hold[gi]),
        .restart_busy (busy_vec[gi])
      );
    end
  endgenerate

  // Block peripheral register access while stopped or just restarted
  assign periph_restart_busy = busy_vec;
  assign periph_access_block = periph_reset_hold | busy_vec;

  // Named steps of a register write
  sequence s_write_analog;
    access & pwrite & pstrb[0] & ~ack_q & (paddr == pmd_bank_pkg::ADDR_ANALOG);
  endsequence

  a_analog_mask: assert property (@(posedge ref_clk) disable iff (rst)
    s_write_analog |=> (s_q.analog_disable & ~pmd_bank_pkg::MASK_ANALOG) == 8'h00)
    else $error("analog empty bits set");

  a_timer_write: assert property (@(posedge ref_clk) disable iff (rst)
    setup_wr & ~ack_q & (paddr == pmd_bank_pkg::ADDR_TIMER_NCO) |=> s_q.timer_nco_disable == $past(wbyte))
    else $error("timer register not written");

  a_reset_clear: assert property (@(posedge ref_clk)
    rst |=> (off_vec == 56'h00_0000_0000_0000))
    else $error("disable bits not cleared by reset");

  a_zero_fuse: assert property (@(posedge ref_clk) disable iff (rst)
    !s_q.fuse_allows |=> !periph_reset_hold[40])
    else $error("zero-cross stopped without fuse");

  a_stop_path: assert property (@(posedge ref_clk) disable iff (rst)
    off_vec[56-1] |=> periph_reset_hold[55] && !periph_clk_en[55])
    else $error("oscillator gen not stopped");

  a_restart_busy: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(periph_reset_hold[0]) |-> periph_restart_busy[0] ##1 !periph_restart_busy[0] || periph_reset_hold[0])
    else $error("restart hold-off wrong length");

  a_block_stop: assert property (@(posedge ref_clk) disable iff (rst)
    off_vec[8] |=> periph_access_block[8])
    else $error("stopped peripheral not blocked");

  a_serial_mask: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.serial_port_disable & ~pmd_bank_pkg::MASK_SERIAL) == 8'h00 &&
    (s_q.dma_engine_disable & ~pmd_bank_pkg::MASK_DMA_ENGINE) == 8'h00 &&
    (s_q.waveform_gen_disable & ~pmd_bank_pkg::MASK_WAVEFORM) == 8'h00 &&
    (s_q.logic_cell_disable & ~pmd_bank_pkg::MASK_LOGIC_CELL) == 8'h00)
    else $error("empty bits set");

  a_pwm_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.pwm_capture_disable[7] |=> !periph_clk_en[39])
    else $error("pwm eight not stopped");

  a_bus_answer: assert property (@(posedge ref_clk) disable iff (rst)
    access & ~ack_q |=> pready)
    else $error("no answer in one wait");

  a_timer_zero: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.timer_nco_disable[0] |=> periph_reset_hold[48] && !periph_clk_en[48])
    else $error("timer zero not stopped");

  a_dac_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.analog_disable[6] |=> periph_reset_hold[46])
    else $error("dac not stopped");

  a_zero_allowed: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.fuse_allows && s_q.analog_disable[0] |=> periph_reset_hold[40])
    else $error("zero-cross not stopped with fuse");

  a_capcomp_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.pwm_capture_disable[0] |=> periph_reset_hold[32])
    else $error("capture unit one not stopped");

  a_wave_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.waveform_gen_disable[5] |=> periph_reset_hold[29])
    else $error("waveform one not stopped");

  a_uart_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.serial_port_disable[5] |=> periph_reset_hold[21])
    else $error("uart two not stopped");

  a_smt_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.logic_cell_disable[5] |=> periph_reset_hold[13])
    else $error("signal timer not stopped");

  a_dsm_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.logic_cell_disable[0] |=> periph_reset_hold[8])
    else $error("modulator not stopped");

  a_dma_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.dma_engine_disable[1] |=> periph_reset_hold[1])
    else $error("dma two not stopped");

  a_run_path: assert property (@(posedge ref_clk) disable iff (rst)
    !off_vec[20] |=> periph_clk_en[20] && !periph_reset_hold[20])
    else $error("enabled peripheral not running");

  a_read_upper: assert property (@(posedge ref_clk) disable iff (rst)
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  a_error_unmapped: assert property (@(posedge ref_clk) disable iff (rst)
    access & ~ack_q & ~addr_hit |=> pslverr)
    else $error("unmapped access without error");

  a_strobe_refuse: assert property (@(posedge ref_clk) disable iff (rst)
    access & pwrite & ~pstrb[0] & ~ack_q & (paddr == pmd_bank_pkg::ADDR_TIMER_NCO) |=>
      $stable(s_q.timer_nco_disable))
    else $error("write without byte strobe taken");

  a_pready_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  a_reset_open: assert property (@(posedge ref_clk)
    rst |=> (periph_clk_en == {56{1'b1}}) && (periph_reset_hold == 56'h00_0000_0000_0000))
    else $error("gates not open after reset");

  a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
    access & ~ack_q & ~pwrite & (paddr == pmd_bank_pkg::ADDR_STATUS) |=> prdata[0] == $past(busy_any))
    else $error("status word wrong");

endmodule

//--- verification/periph_model.sv
`timescale 1ns/1ps
// Behavioural model of the peripherals that sit behind the disable bank gates
module periph_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [55:0] clk_en,
  input  wire logic [55:0] reset_hold,
  output logic      [55:0] running
);
  // A peripheral leaves reset only once its clock runs and no hold is applied
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      running <= '0;
    end else begin
      running <= ~reset_hold & (running | clk_en);
    end
  end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
// Self-checking testbench of the peripheral disable bank with APB master and read scoreboard
module tb_top;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, fuse, seen_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [55:0] clk_en, hold, busy, blk, running, all_mask;
  logic [32:0] exp_q[$];
  logic [11:0] addrs[7];
  logic [7:0]  masks[7];
  logic [7:0]  rv[7];
  int          bad_count, num_checks;

  pmd_bank pmd_bank_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .zero_cross_fuse_word(fuse), .periph_clk_en(clk_en), .periph_reset_hold(hold),
    .periph_restart_busy(busy), .periph_access_block(blk));
  periph_model periph_model_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reset_hold(hold),
    .running(running));

  // Clock at 25 MHz
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Compare one result against its expectation
  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, 4'hF);
  endtask

  // Scoreboard: each completed read takes the oldest expectation
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      chk({23'h00_0000, pslverr, prdata}, {23'h00_0000, exp_q.pop_front()});
    end
    if ((|busy) === 1'b1) begin
      seen_busy = 1'b1;
    end
  end

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    fuse = 1'b1;
    seen_busy = 1'b0;
    addrs = '{pmd_bank_pkg::ADDR_TIMER_NCO, pmd_bank_pkg::ADDR_ANALOG, pmd_bank_pkg::ADDR_PWM_CAPTURE,
      pmd_bank_pkg::ADDR_WAVEFORM, pmd_bank_pkg::ADDR_SERIAL, pmd_bank_pkg::ADDR_LOGIC_CELL,
      pmd_bank_pkg::ADDR_DMA_ENGINE};
    masks = '{pmd_bank_pkg::MASK_TIMER_NCO, pmd_bank_pkg::MASK_ANALOG, pmd_bank_pkg::MASK_PWM_CAPTURE,
      pmd_bank_pkg::MASK_WAVEFORM, pmd_bank_pkg::MASK_SERIAL, pmd_bank_pkg::MASK_LOGIC_CELL,
      pmd_bank_pkg::MASK_DMA_ENGINE};
    all_mask = {masks[0], masks[1], masks[2], masks[3], masks[4], masks[5], masks[6]};
    void'($urandom(1));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(addrs[i], 33'h0_0000_0000);
    $display("Test reset values done");
    // Every bit set: only implemented bits stick and stop their peripheral
    for (int i = 0; i < 7; i++) begin
      wr(addrs[i], 8'hFF);
      rd(addrs[i], {25'h000_0000, masks[i]});
    end
    repeat (3) @(posedge ref_clk);
    chk(clk_en, ~all_mask);
    chk(hold, all_mask);
    chk(running, ~all_mask);
    chk(blk, all_mask);
    $display("Test all disabled done");
    // Clearing restarts every peripheral with a hold-off pulse
    seen_busy = 1'b0;
    for (int i = 0; i < 7; i++) wr(addrs[i], 8'h00);
    repeat (3) @(posedge ref_clk);
    chk(clk_en, {56{1'b1}});
    chk(running, {56{1'b1}});
    chk({55'h0, seen_busy}, 56'h1);
    chk(blk, 56'h00_0000_0000_0000);
    rd(pmd_bank_pkg::ADDR_STATUS, 33'h0_0000_0000);
    $display("Test restart done");
    // Random patterns, then writes without the byte strobe are refused
    for (int i = 0; i < 7; i++) begin
      rv[i] = 8'($urandom);
      wr(addrs[i], rv[i]);
      rd(addrs[i], {25'h000_0000, rv[i] & masks[i]});
      apb(1'b1, addrs[i], 32'h0000_00FF, 4'hE);
      rd(addrs[i], {25'h000_0000, rv[i] & masks[i]});
    end
    $display("Test random and strobe done");
    // Without the fuse the zero-cross bit does not stop its peripheral
    fuse <= 1'b0;
    wr(pmd_bank_pkg::ADDR_ANALOG, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk({55'h0, clk_en[40]}, 56'h1);
    rd(12'h100, {1'b1, pmd_bank_pkg::READ_ZERO});
    $display("Test fuse and unmapped done");
    // Reset in mid-run clears a written register
    wr(pmd_bank_pkg::ADDR_TIMER_NCO, 8'hA5);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(pmd_bank_pkg::ADDR_TIMER_NCO, 33'h0_0000_0000);
    repeat (4) @(posedge ref_clk);
    $display("Test second reset done");
    finish_test();
  end
endmodule
